// ### dv/epie_pin_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// external pin driver
// ------------------------------------------------------------
module epie_pin_model (
  input wire logic [8:0] lvl,
  output logic extIntPinA,
  output logic extIntPinB,
  output logic [5:0] wakePin,
  output logic sleepDirect
);
  // pins move off the clock grid, as a real outside source would
  // first copy once the level word has settled, then follow every change
  always begin
    #2.3;
    extIntPinA = lvl[0];
    extIntPinB = lvl[1];
    wakePin = lvl[7:2];
    sleepDirect = lvl[8];
    @(lvl);
  end
endmodule // epie_pin_model

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  import epie_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, dtCtl = 1'b0, cpuIntMask = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, isInt = 8'hff;
  logic [8:0] lvl = 9'h0ff;
  logic extIntPinA, extIntPinB, sleepDirect, pinAReq, pinBReq, wakeReq, directTransitionReq, converterTrigger, irq;
  logic [5:0] wakePin;
  int failures = 0, num_checks = 0, trigCnt = 0, i;
  logic [19:0] rows [8] = '{20'h0ff79, 20'h00070, 20'h1ffff, 20'h100c0, 20'h2ffb9, 20'h20010, 20'h8ff00, 20'h5ff00};
  always #2.5 ref_clk = ~ref_clk;
  epie_pin_model u_epie_pin_model (.lvl(lvl), .extIntPinA(extIntPinA), .extIntPinB(extIntPinB),
    .wakePin(wakePin), .sleepDirect(sleepDirect));
  epie_top u_epie_top (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .extIntPinA(extIntPinA), .extIntPinB(extIntPinB), .wakePin(wakePin),
    .pinAIsInt(isInt[0]), .pinBIsInt(isInt[1]), .wakeIsInt(isInt[7:2]), .sleepDirect(sleepDirect),
    .directTransitionControl(dtCtl), .cpuIntMask(cpuIntMask), .pinAReq(pinAReq), .pinBReq(pinBReq),
    .wakeReq(wakeReq), .directTransitionReq(directTransitionReq), .converterTrigger(converterTrigger), .irq(irq));
  // count one-cycle trigger pulses
  always @(posedge ref_clk) begin
    if (converterTrigger === 1'b1) trigCnt <= trigCnt + 1;
  end
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk8(regRdata, exp);
  endtask
  // move one pin and let sync, edge and flag stages settle
  task automatic pin(input int idx, input logic v);
    @(posedge ref_clk);
    lvl[idx] <= v;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, run needs about 320 cycles
  initial begin
    #50000;
    failures++;
    complete_run();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    cpuIntMask <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rchk(rows[i][19:16], rows[i][7:0]);
    end
    $display("table test done");
    wr(INT_ON_OFS, 8'ha9);
    wr(EVT_EN_OFS, 8'h07);
    pin(0, 1'b0);
    rchk(PIN_FLAG_OFS, 8'h31);
    chk1(pinAReq, 1'b1);
    chk1(irq, 1'b1);
    pin(0, 1'b1);
    rchk(PIN_FLAG_OFS, 8'h31);
    wr(PIN_FLAG_OFS, 8'h00);
    rchk(PIN_FLAG_OFS, 8'h30);
    chk1(pinAReq, 1'b0);
    wr(EDGE_SEL_OFS, 8'h09);
    pin(0, 1'b0);
    pin(1, 1'b0);
    rchk(PIN_FLAG_OFS, 8'h30);
    pin(0, 1'b1);
    pin(1, 1'b1);
    rchk(PIN_FLAG_OFS, 8'h39);
    chk1(pinBReq, 1'b1);
    @(posedge ref_clk);
    cpuIntMask <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk1(pinAReq | pinBReq, 1'b0);
    wr(PIN_FLAG_OFS, 8'h08);
    rchk(PIN_FLAG_OFS, 8'h38);
    @(posedge ref_clk);
    cpuIntMask <= 1'b0;
    wr(INT_ON_OFS, 8'h20);
    repeat (5) @(posedge ref_clk);
    #1;
    chk1(pinBReq, 1'b0);
    // flag clear lands on the very edge at which pin A's edge pulse stands
    pin(0, 1'b0);
    @(posedge ref_clk);
    lvl[0] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wr(PIN_FLAG_OFS, 8'h00);
    rchk(PIN_FLAG_OFS, 8'h31);
    wr(PIN_FLAG_OFS, 8'h00);
    // pin not configured as interrupt input: edge must not set the flag
    @(posedge ref_clk);
    isInt <= 8'hfe;
    pin(0, 1'b0);
    pin(0, 1'b1);
    rchk(PIN_FLAG_OFS, 8'h30);
    @(posedge ref_clk);
    isInt <= 8'hff;
    $display("pin test done");
    wr(WAKE_SEL_OFS, 8'h20);
    for (i = 2; i < 8; i++) pin(i, 1'b0);
    rchk(WAKE_FLAG_OFS, 8'hdf);
    chk8(trigCnt[7:0], 8'h00);
    pin(7, 1'b1);
    rchk(WAKE_FLAG_OFS, 8'hff);
    chk8(trigCnt[7:0], 8'h01);
    chk1(wakeReq, 1'b1);
    wr(INT_ON_OFS, 8'h80);
    repeat (3) @(posedge ref_clk);
    #1;
    chk1(wakeReq, 1'b0);
    $display("wake test done");
    @(posedge ref_clk);
    dtCtl <= 1'b1;
    pin(8, 1'b1);
    rchk(PIN_FLAG_OFS, 8'hb0);
    chk1(directTransitionReq, 1'b1);
    wr(INT_ON_OFS, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk1(directTransitionReq, 1'b0);
    rchk(EVT_STAT_OFS, 8'h07);
    wr(EVT_STAT_OFS, 8'h00);
    wr(EVT_CLR_OFS, 8'h01);
    rchk(EVT_STAT_OFS, 8'h06);
    chk1(irq, 1'b1);
    wr(EVT_EN_OFS, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1;
    chk1(irq, 1'b0);
    $display("event test done");
    // pins back to idle so that release of reset shows no edge
    @(posedge ref_clk);
    lvl <= 9'h0ff;
    dtCtl <= 1'b0;
    arst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rchk(EDGE_SEL_OFS, 8'h70);
    rchk(WAKE_SEL_OFS, 8'hc0);
    rchk(INT_ON_OFS, 8'h10);
    rchk(PIN_FLAG_OFS, 8'h30);
    rchk(WAKE_FLAG_OFS, 8'hc0);
    rchk(EVT_STAT_OFS, 8'h00);
    $display("reset test done");
    complete_run();
  end
endmodule // testbench

// ### rtl/epie_edge_detect.sv
`timescale 1ns/10ps
// two-flop synchroniser plus selected-edge pulse for one pin
module epie_edge_detect (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic pinIn,
  input wire logic riseSel,
  output logic edgePulse
);
  logic sync1_reg, sync2_reg, prev_reg, edge_reg;
  logic edgeNext;

  // select the edge direction
  always_comb begin
    edgeNext = riseSel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);
  end

  // synchronise and remember the last sampled level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      edge_reg <= 1'b0;
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      edge_reg <= edgeNext;
    end
  end

  assign edgePulse = edge_reg;

  property p_pulse_one;
    @(posedge ref_clk) disable iff (!arst_n)
      edgePulse |=> !edgePulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("edge pulse longer than one cycle");
endmodule // epie_edge_detect

// ### rtl/epie_pkg.sv
package epie_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] EDGE_SEL_OFS = 4'h0; // ext_int_edge_select
  localparam logic [3:0] WAKE_SEL_OFS = 4'h1; // wakeup_edge_select
  localparam logic [3:0] INT_ON_OFS = 4'h2; // pin_interrupt_enable
  localparam logic [3:0] PIN_FLAG_OFS = 4'h3; // pin_request_flags
  localparam logic [3:0] WAKE_FLAG_OFS = 4'h4; // wakeup_request_flags
  localparam logic [3:0] EVT_STAT_OFS = 4'h5; // sticky event status, read only
  localparam logic [3:0] EVT_CLR_OFS = 4'h6; // event clear, write only
  localparam logic [3:0] EVT_EN_OFS = 4'h7; // event interrupt enable

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PIN_A_BIT = 0;
  localparam int PIN_B_BIT = 3;
  localparam int WAKE_ON_BIT = 5;
  localparam int DT_BIT = 7;
  localparam int WAKE_CNT = 6;

  // ------------------------------------------------------------
  // fixed read values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] EDGE_SEL_FIX = 8'h70;
  localparam logic [7:0] EDGE_SEL_WMASK = 8'h09;
  localparam logic [7:0] WAKE_SEL_FIX = 8'hc0;
  localparam logic [7:0] WAKE_SEL_WMASK = 8'h3f;
  localparam logic [7:0] INT_ON_FIX = 8'h10;
  localparam logic [7:0] INT_ON_WMASK = 8'ha9;
  localparam logic [7:0] PIN_FLAG_FIX = 8'h30;
  localparam logic [7:0] PIN_FLAG_WMASK = 8'h89;
  localparam logic [7:0] WAKE_FLAG_FIX = 8'hc0;
  localparam logic [7:0] WAKE_FLAG_WMASK = 8'h3f;
  localparam logic [7:0] EVT_WMASK = 8'h07;
  localparam logic [7:0] RESET_VAL = 8'h00;
endpackage

// ### rtl/epie_top.sv
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
// How it works
// - each pin raises a request only on its selected edge direction
// - edge select bit 3 sets pin B edge, 0 falling, 1 rising
// - edge select bit 0 sets pin A edge, 0 falling, 1 rising
// - wakeup edge bits 0..5 set wake pin edges, 0 falling, 1 rising
// - wake pin 5 polarity also governs the converter trigger
// - enable bit 7 gates direct-transition requests
// - enable bit 5 gates all six wakeup requests together
// - enable bit 3 gates pin B, bit 0 gates pin A
// - edge select bits 6..4 and wakeup bits 7..6 read 1, unwritable
// - bits 2..1 of edge select and enable read 0
// - enable bit 4 reads 1; edge bit 7, enable bit 6 read 0
// - a request meeting a clear is still taken afterwards
// - pin flags set on selected edge, cleared by writing 0
// - each wake pin flag sets on its edge, cleared by writing 0
// - direct-transition flag sets on sleep with control bit set
// - requests stay masked while cpu mask bit is 1
module epie_top
  import epie_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic extIntPinA,
  input wire logic extIntPinB,
  input wire logic [5:0] wakePin,
  input wire logic pinAIsInt,
  input wire logic pinBIsInt,
  input wire logic [5:0] wakeIsInt,
  input wire logic sleepDirect,
  input wire logic directTransitionControl,
  input wire logic cpuIntMask,
  output logic pinAReq,
  output logic pinBReq,
  output logic wakeReq,
  output logic directTransitionReq,
  output logic converterTrigger,
  output logic irq
);
  import epie_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] edgeSel_reg, edgeSel_next;
  logic [7:0] wakeSel_reg, wakeSel_next;
  logic [7:0] intOn_reg, intOn_next;
  logic [7:0] pinFlag_reg, pinFlag_next;
  logic [7:0] wakeFlag_reg, wakeFlag_next;
  logic [7:0] evtStat_reg, evtStat_next;
  logic [7:0] evtEn_reg, evtEn_next;
  logic [7:0] rdata_reg, rdata_next;
  logic pinAReq_reg, pinBReq_reg, wakeReq_reg, dtReq_reg, irq_reg, trig_reg;
  logic pinAReq_next, pinBReq_next, wakeReq_next, dtReq_next, irq_next, trig_next;
  logic sleep1_reg, sleep2_reg, sleepPrev_reg;
  logic mask1_reg, mask2_reg;
  logic edgeA, edgeB, dtEvent;
  logic [5:0] edgeWake;

  // write hits a given offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs, input logic s);
    hit = s && (a == ofs);
  endfunction

  // ------------------------------------------------------------
  // pin edge detection
  // ------------------------------------------------------------
  epie_edge_detect uPinA (.ref_clk(ref_clk), .arst_n(arst_n), .pinIn(extIntPinA),
    .riseSel(edgeSel_reg[PIN_A_BIT]), .edgePulse(edgeA));
  epie_edge_detect uPinB (.ref_clk(ref_clk), .arst_n(arst_n), .pinIn(extIntPinB),
    .riseSel(edgeSel_reg[PIN_B_BIT]), .edgePulse(edgeB));

  genvar gi;
  generate
    for (gi = 0; gi < WAKE_CNT; gi++) begin : gWake
      epie_edge_detect uWake (.ref_clk(ref_clk), .arst_n(arst_n), .pinIn(wakePin[gi]),
        .riseSel(wakeSel_reg[gi]), .edgePulse(edgeWake[gi]));
    end
  endgenerate

  // sleep strobe and mask pass two flops; direct transition on rising strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep1_reg <= 1'b0;
      sleep2_reg <= 1'b0;
      sleepPrev_reg <= 1'b0;
      mask1_reg <= 1'b1;
      mask2_reg <= 1'b1;
    end else begin
      sleep1_reg <= sleepDirect;
      sleep2_reg <= sleep1_reg;
      sleepPrev_reg <= sleep2_reg;
      mask1_reg <= cpuIntMask;
      mask2_reg <= mask1_reg;
    end
  end
  assign dtEvent = sleep2_reg & ~sleepPrev_reg & directTransitionControl;

  // ------------------------------------------------------------
  // register writes and flags
  // ------------------------------------------------------------
  always_comb begin
    edgeSel_next = edgeSel_reg;
    wakeSel_next = wakeSel_reg;
    intOn_next = intOn_reg;
    pinFlag_next = pinFlag_reg;
    wakeFlag_next = wakeFlag_reg;
    evtEn_next = evtEn_reg;
    evtStat_next = evtStat_reg;
    if (hit(regAddr, EDGE_SEL_OFS, regWr)) edgeSel_next = regWdata & EDGE_SEL_WMASK;
    if (hit(regAddr, WAKE_SEL_OFS, regWr)) wakeSel_next = regWdata & WAKE_SEL_WMASK;
    if (hit(regAddr, INT_ON_OFS, regWr)) intOn_next = regWdata & INT_ON_WMASK;
    if (hit(regAddr, EVT_EN_OFS, regWr)) evtEn_next = regWdata & EVT_WMASK;
    // write 0 clears a pin or wake flag, writing 1 leaves it; event clear clears on 1
    if (hit(regAddr, PIN_FLAG_OFS, regWr)) pinFlag_next = pinFlag_reg & (regWdata | ~PIN_FLAG_WMASK);
    if (hit(regAddr, WAKE_FLAG_OFS, regWr)) wakeFlag_next = wakeFlag_reg & (regWdata | ~WAKE_FLAG_WMASK);
    if (hit(regAddr, EVT_CLR_OFS, regWr)) evtStat_next = evtStat_reg & ~(regWdata & EVT_WMASK);
    // sets after clears so an arriving edge wins
    if (edgeA && pinAIsInt) pinFlag_next[PIN_A_BIT] = 1'b1;
    if (edgeB && pinBIsInt) pinFlag_next[PIN_B_BIT] = 1'b1;
    if (dtEvent) pinFlag_next[DT_BIT] = 1'b1;
    wakeFlag_next[5:0] = wakeFlag_next[5:0] | (edgeWake & wakeIsInt);
    evtStat_next[0] = evtStat_next[0] | (edgeA & pinAIsInt) | (edgeB & pinBIsInt);
    evtStat_next[1] = evtStat_next[1] | (|(edgeWake & wakeIsInt));
    evtStat_next[2] = evtStat_next[2] | dtEvent;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      edgeSel_reg <= RESET_VAL;
      wakeSel_reg <= RESET_VAL;
      intOn_reg <= RESET_VAL;
      pinFlag_reg <= RESET_VAL;
      wakeFlag_reg <= RESET_VAL;
      evtStat_reg <= RESET_VAL;
      evtEn_reg <= RESET_VAL;
    end else begin
      edgeSel_reg <= edgeSel_next;
      wakeSel_reg <= wakeSel_next;
      intOn_reg <= intOn_next;
      pinFlag_reg <= pinFlag_next;
      wakeFlag_reg <= wakeFlag_next;
      evtStat_reg <= evtStat_next;
      evtEn_reg <= evtEn_next;
    end
  end

  // ------------------------------------------------------------
  // requests, trigger, interrupt and read data
  // ------------------------------------------------------------
  always_comb begin
    pinAReq_next = pinFlag_reg[PIN_A_BIT] & intOn_reg[PIN_A_BIT] & ~mask2_reg;
    pinBReq_next = pinFlag_reg[PIN_B_BIT] & intOn_reg[PIN_B_BIT] & ~mask2_reg;
    wakeReq_next = (|wakeFlag_reg[5:0]) & intOn_reg[WAKE_ON_BIT] & ~mask2_reg;
    dtReq_next = pinFlag_reg[DT_BIT] & intOn_reg[DT_BIT] & ~mask2_reg;
    trig_next = edgeWake[5];
    irq_next = |(evtStat_reg & evtEn_reg);
    rdata_next = RESET_VAL;
    if (regRd) begin
      case (regAddr)
        EDGE_SEL_OFS: rdata_next = edgeSel_reg | EDGE_SEL_FIX;
        WAKE_SEL_OFS: rdata_next = wakeSel_reg | WAKE_SEL_FIX;
        INT_ON_OFS: rdata_next = intOn_reg | INT_ON_FIX;
        PIN_FLAG_OFS: rdata_next = pinFlag_reg | PIN_FLAG_FIX;
        WAKE_FLAG_OFS: rdata_next = wakeFlag_reg | WAKE_FLAG_FIX;
        EVT_STAT_OFS: rdata_next = evtStat_reg;
        EVT_EN_OFS: rdata_next = evtEn_reg;
        default: rdata_next = RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinAReq_reg <= 1'b0;
      pinBReq_reg <= 1'b0;
      wakeReq_reg <= 1'b0;
      dtReq_reg <= 1'b0;
      trig_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= RESET_VAL;
    end else begin
      pinAReq_reg <= pinAReq_next;
      pinBReq_reg <= pinBReq_next;
      wakeReq_reg <= wakeReq_next;
      dtReq_reg <= dtReq_next;
      trig_reg <= trig_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pinAReq = pinAReq_reg;
  assign pinBReq = pinBReq_reg;
  assign wakeReq = wakeReq_reg;
  assign directTransitionReq = dtReq_reg;
  assign converterTrigger = trig_reg;
  assign irq = irq_reg;
  assign regRdata = rdata_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_edge_sel_read;
    @(posedge ref_clk) disable iff (!arst_n)
      regRd && regAddr == EDGE_SEL_OFS |=> regRdata[6:4] == 3'h7 && regRdata[7] == 1'b0 && regRdata[2:1] == 2'h0;
  endproperty
  a_edge_sel_read: assert property (p_edge_sel_read) else $error("edge select reserved bits wrong");
  property p_wake_sel_read;
    @(posedge ref_clk) disable iff (!arst_n)
      regRd && regAddr == WAKE_SEL_OFS |=> regRdata[7:6] == 2'h3;
  endproperty
  a_wake_sel_read: assert property (p_wake_sel_read) else $error("wakeup select reserved bits wrong");
  property p_int_on_read;
    @(posedge ref_clk) disable iff (!arst_n)
      regRd && regAddr == INT_ON_OFS |=> regRdata[4] && !regRdata[6] && regRdata[2:1] == 2'h0;
  endproperty
  a_int_on_read: assert property (p_int_on_read) else $error("enable reserved bits wrong");
  property p_pin_a_set;
    @(posedge ref_clk) disable iff (!arst_n)
      edgeA && pinAIsInt |=> pinFlag_reg[PIN_A_BIT];
  endproperty
  a_pin_a_set: assert property (p_pin_a_set) else $error("pin A flag not set");
  property p_wake_set;
    @(posedge ref_clk) disable iff (!arst_n)
      edgeWake[0] && wakeIsInt[0] |=> wakeFlag_reg[0];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");
  property p_wake_req;
    @(posedge ref_clk) disable iff (!arst_n)
      (|wakeFlag_reg[5:0]) && intOn_reg[WAKE_ON_BIT] && !mask2_reg |=> wakeReq;
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wakeup request missing");
  property p_masked;
    @(posedge ref_clk) disable iff (!arst_n)
      mask2_reg |=> !pinAReq && !pinBReq && !wakeReq && !directTransitionReq;
  endproperty
  a_masked: assert property (p_masked) else $error("request while masked");
  property p_dt_block;
    @(posedge ref_clk) disable iff (!arst_n)
      !intOn_reg[DT_BIT] |=> !directTransitionReq;
  endproperty
  a_dt_block: assert property (p_dt_block) else $error("direct request while disabled");
  property p_pin_b_req;
    @(posedge ref_clk) disable iff (!arst_n)
      pinBReq |-> $past(pinFlag_reg[PIN_B_BIT]) && $past(intOn_reg[PIN_B_BIT]);
  endproperty
  a_pin_b_req: assert property (p_pin_b_req) else $error("pin B request without cause");

  c_pin_a: cover property (@(posedge ref_clk) disable iff (!arst_n) pinAReq);
  c_wake: cover property (@(posedge ref_clk) disable iff (!arst_n) wakeReq);
  c_dt: cover property (@(posedge ref_clk) disable iff (!arst_n) directTransitionReq);
  c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n) irq);
endmodule // epie_top
